// ### logic/cat_timebase.sv
// Counter array timebase: shared 16-bit counter, source select, snapshot
// read, overflow flag and interrupt. Assumes an AXI4-Lite master on CLK;
// the count, oscillator and idle inputs arrive from outside the domain.
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps

// How it works
// - Counter is two separately addressed bytes, low and high.
// - Reading low byte latches high byte; high byte read returns that copy.
// - Register reads never stop or change the counting.
// - Select field picks clk/12, clk/4, timer-0 wrap, count pin, clk, osc/8.
// - Oscillator-divided tick is synchronised to the clock before use.
// - Wrap from all ones to zero sets the overflow flag.
// - Overflow request only while the overflow interrupt enable is set.
// - Flag stays set on interrupt entry; software clears it.
// - Idle suspend bit halts counting while the processor idles.
// - Overflow during a control register write is lost from the flag; status keeps it.
// - One counter value is shared by six capture/compare modules.
module cat_timebase (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [cat_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [cat_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    input wire logic EXT_COUNT_IN,
    input wire logic EXT_OSC_DIV8,
    input wire logic TIMER0_OVF,
    input wire logic CPU_IDLE,
    output logic [15:0] COUNT_VALUE,
    output logic OVF_REQ,
    output logic IRQ
);
    import cat_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [7:0] snap_ff;
    logic [7:0] mode_ff;
    logic flag_ff;
    logic [CTRL_MATCH_W-1:0] match_ff;
    logic [7:0] sts_ff;
    logic [7:0] msk_ff;
    logic [1:0] cpin_sync_ff;
    logic cpin_prev_ff;
    logic [1:0] osc_sync_ff;
    logic osc_prev_ff;
    logic [1:0] idle_sync_ff;
    logic [3:0] div_slow_ff;
    logic [1:0] div_fast_ff;
    logic tick;
    logic run_tick;
    logic cpin_fall;
    logic osc_rise;
    logic wr_go;
    logic ar_go;
    logic wr_lo;
    logic wr_hi;
    logic cnt_wr;
    logic ctrl_wr;
    logic ovf_evt;
    logic [31:0] rd_mux;
    logic rd_hit;
    logic wr_hit;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    cat_tb_t tbs;

    assign tbs = cat_tb_t'(mode_ff[MODE_TBS_LSB +: 3]);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    // Pins are asynchronous; edge detectors only look at second stage.
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cpin_sync_ff <= 2'h0;
            cpin_prev_ff <= 1'b0;
            osc_sync_ff <= 2'h0;
            osc_prev_ff <= 1'b0;
            idle_sync_ff <= 2'h0;
        end else begin
            cpin_sync_ff <= {cpin_sync_ff[0], EXT_COUNT_IN};
            cpin_prev_ff <= cpin_sync_ff[1];
            osc_sync_ff <= {osc_sync_ff[0], EXT_OSC_DIV8};
            osc_prev_ff <= osc_sync_ff[1];
            idle_sync_ff <= {idle_sync_ff[0], CPU_IDLE};
        end
    end

    // Count input edges faster than clk/4 may merge after sync
    assign cpin_fall = cpin_prev_ff & ~cpin_sync_ff[1];
    assign osc_rise = osc_sync_ff[1] & ~osc_prev_ff;

    // ------------------------------------------------------------
    // Prescalers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            div_slow_ff <= 4'h0;
            div_fast_ff <= 2'h0;
        end else begin
            div_slow_ff <= (div_slow_ff == DIV_SLOW_LAST) ? 4'h0
                         : div_slow_ff + 4'h1;
            div_fast_ff <= div_fast_ff + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Timebase select and idle suspend
    // ------------------------------------------------------------
    always_comb begin
        unique case (tbs)
            TB_DIV12: tick = (div_slow_ff == DIV_SLOW_LAST);
            TB_DIV4: tick = (div_fast_ff == DIV_FAST_LAST);
            TB_T0OVF: tick = TIMER0_OVF;
            TB_CNT_PIN: tick = cpin_fall;
            TB_SYS: tick = 1'b1;
            TB_OSC8: tick = osc_rise;
            default: tick = 1'b0;
        endcase
    end

    assign run_tick = tick
        & ~(mode_ff[MODE_IDLE_BIT] & idle_sync_ff[1]);

    // ------------------------------------------------------------
    // Bus handshakes
    // ------------------------------------------------------------
    // Address and data are taken together; simpler than two holding regs
    assign wr_go = S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_ff;
    assign ar_go = S_AXI_ARVALID & ~rvalid_ff;
    assign S_AXI_AWREADY = wr_go;
    assign S_AXI_WREADY = wr_go;
    assign S_AXI_ARREADY = ~rvalid_ff;
    assign wr_lo = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == ADDR_CNT_LO);
    assign wr_hi = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == ADDR_CNT_HI);
    assign cnt_wr = wr_lo | wr_hi;
    assign ctrl_wr = wr_go & S_AXI_WSTRB[0] & (S_AXI_AWADDR == ADDR_CTRL);

    always_comb begin
        wr_hit = 1'b1;
        unique case (S_AXI_AWADDR)
            ADDR_CNT_LO, ADDR_CNT_HI, ADDR_MODE, ADDR_CTRL, ADDR_STS,
            ADDR_MSK: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_comb begin
        nxt_cnt = cnt_ff;
        if (run_tick) begin
            nxt_cnt = cnt_ff + 16'h0001;
        end
        if (wr_lo) begin
            nxt_cnt[7:0] = S_AXI_WDATA[7:0];
        end
        if (wr_hi) begin
            nxt_cnt[15:8] = S_AXI_WDATA[7:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            cnt_ff <= CNT_RST;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign ovf_evt = run_tick & ~cnt_wr & (cnt_ff == CNT_MAX);
    assign COUNT_VALUE = cnt_ff;

    // ------------------------------------------------------------
    // Snapshot latch
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            snap_ff <= 8'h00;
        end else if (ar_go && S_AXI_ARADDR == ADDR_CNT_LO) begin
            snap_ff <= cnt_ff[15:8];
        end
    end

    // ------------------------------------------------------------
    // Mode, control, status and mask registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            mode_ff <= MODE_RST;
            msk_ff <= MSK_RST;
        end else if (wr_go && S_AXI_WSTRB[0]) begin
            if (S_AXI_AWADDR == ADDR_MODE) begin
                mode_ff <= S_AXI_WDATA[7:0];
            end
            if (S_AXI_AWADDR == ADDR_MSK) begin
                msk_ff <= S_AXI_WDATA[7:0];
            end
        end
    end

    // A control write replaces the flag, so a wrap in that cycle is lost
    always_ff @(posedge CLK) begin
        if (RESET) begin
            flag_ff <= CTRL_RST[CTRL_OVF_FLAG_BIT];
            match_ff <= CTRL_RST[CTRL_MATCH_W-1:0];
        end else if (ctrl_wr) begin
            flag_ff <= S_AXI_WDATA[CTRL_OVF_FLAG_BIT];
            match_ff <= S_AXI_WDATA[CTRL_MATCH_W-1:0];
        end else if (ovf_evt) begin
            flag_ff <= 1'b1;
        end
    end

    // Sticky status: a new event beats the read-clear in the same cycle
    always_ff @(posedge CLK) begin
        if (RESET) begin
            sts_ff <= STS_RST;
        end else begin
            if (ar_go && S_AXI_ARADDR == ADDR_STS) begin
                sts_ff <= 8'h00;
            end
            if (ovf_evt) begin
                sts_ff[STS_OVF_BIT] <= 1'b1;
            end
        end
    end

    assign OVF_REQ = flag_ff & mode_ff[MODE_OVF_IE_BIT];
    assign IRQ = |(sts_ff & msk_ff);

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (S_AXI_ARADDR)
            ADDR_CNT_LO: rd_mux[7:0] = cnt_ff[7:0];
            ADDR_CNT_HI: rd_mux[7:0] = snap_ff;
            ADDR_MODE: rd_mux[7:0] = mode_ff;
            ADDR_CTRL: rd_mux[7:0] = {flag_ff, 1'b0, match_ff};
            ADDR_STS: rd_mux[7:0] = sts_ff;
            ADDR_MSK: rd_mux[7:0] = msk_ff;
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RESET) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= RESP_OKAY;
        end else if (ar_go) begin
            rvalid_ff <= 1'b1;
            rdata_ff <= rd_mux;
            rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
        end else if (S_AXI_RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (RESET) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_hit ? RESP_OKAY : RESP_DECERR;
        end else if (S_AXI_BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign S_AXI_BVALID = bvalid_ff;
    assign S_AXI_BRESP = bresp_ff;
    assign S_AXI_RVALID = rvalid_ff;
    assign S_AXI_RDATA = rdata_ff;
    assign S_AXI_RRESP = rresp_ff;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    property p_wrap_sets_flag;
        run_tick && !cnt_wr && !ctrl_wr && cnt_ff == CNT_MAX
            |=> flag_ff && cnt_ff == 16'h0000;
    endproperty
    a_wrap_sets_flag: assert property (p_wrap_sets_flag)
        else $error("wrap did not set overflow flag");

    property p_step_one;
        run_tick && !cnt_wr |=> cnt_ff == $past(cnt_ff) + 16'h0001;
    endproperty
    a_step_one: assert property (p_step_one)
        else $error("counter did not advance by one");

    property p_read_no_disturb;
        ar_go && !run_tick && !cnt_wr |=> cnt_ff == $past(cnt_ff);
    endproperty
    a_read_no_disturb: assert property (p_read_no_disturb)
        else $error("read disturbed the counter");

    property p_snap_latch;
        ar_go && S_AXI_ARADDR == ADDR_CNT_LO
            |=> snap_ff == $past(cnt_ff[15:8]);
    endproperty
    a_snap_latch: assert property (p_snap_latch)
        else $error("snapshot missed high byte");

    property p_hi_from_snap;
        ar_go && S_AXI_ARADDR == ADDR_CNT_HI
            |=> S_AXI_RDATA == {24'h000000, $past(snap_ff)};
    endproperty
    a_hi_from_snap: assert property (p_hi_from_snap)
        else $error("high byte read not from snapshot");

    property p_idle_halt;
        mode_ff[MODE_IDLE_BIT] && idle_sync_ff[1] && !cnt_wr
            |=> $stable(cnt_ff);
    endproperty
    a_idle_halt: assert property (p_idle_halt)
        else $error("counter moved during idle suspend");

    property p_req_gate;
        $rose(flag_ff) |-> OVF_REQ == mode_ff[MODE_OVF_IE_BIT];
    endproperty
    a_req_gate: assert property (p_req_gate)
        else $error("overflow request not gated by enable");

    property p_flag_sticky;
        flag_ff && !ctrl_wr |=> flag_ff;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("overflow flag cleared by hardware");

    property p_rmw_loss;
        ctrl_wr && !S_AXI_WDATA[CTRL_OVF_FLAG_BIT] |=> !flag_ff;
    endproperty
    a_rmw_loss: assert property (p_rmw_loss)
        else $error("overflow flag set during control write");

    property p_slow_gap;
        run_tick && tbs == TB_DIV12
            |=> (!run_tick || tbs != TB_DIV12) [*8];
    endproperty
    a_slow_gap: assert property (p_slow_gap)
        else $error("divide by twelve ticked too early");

    property p_sts_sets;
        ovf_evt |=> sts_ff[STS_OVF_BIT];
    endproperty
    a_sts_sets: assert property (p_sts_sets)
        else $error("status missed overflow event");

    c_wrap: cover property (ovf_evt ##1 flag_ff);
    c_lo_then_hi: cover property (ar_go && S_AXI_ARADDR == ADDR_CNT_LO
        ##[1:4] ar_go && S_AXI_ARADDR == ADDR_CNT_HI);
    c_lost_wrap: cover property (ctrl_wr && run_tick && cnt_ff == CNT_MAX);
    c_irq: cover property ($rose(IRQ));

endmodule : cat_timebase

// ### logic/cat_pkg.sv
// Constants for the counter array timebase: register map, fields, resets.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package cat_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CNT_LO = 8'h00;
    localparam logic [7:0] ADDR_CNT_HI = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0c;
    localparam logic [7:0] ADDR_STS = 8'h10;
    localparam logic [7:0] ADDR_MSK = 8'h14;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int MODE_OVF_IE_BIT = 0;
    localparam int MODE_TBS_LSB = 1;
    localparam int MODE_IDLE_BIT = 7;
    localparam int CTRL_OVF_FLAG_BIT = 7;
    localparam int CTRL_MATCH_W = 6;
    localparam int STS_OVF_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CNT_RST = 16'h0000;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] MSK_RST = 8'h00;
    localparam logic [7:0] STS_RST = 8'h00;

    // ------------------------------------------------------------
    // Timebase codes and divider counts
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TB_DIV12 = 3'h0,
        TB_DIV4 = 3'h1,
        TB_T0OVF = 3'h2,
        TB_CNT_PIN = 3'h3,
        TB_SYS = 3'h4,
        TB_OSC8 = 3'h5
    } cat_tb_t;
    localparam logic [3:0] DIV_SLOW_LAST = 4'hb;
    localparam logic [1:0] DIV_FAST_LAST = 2'h3;
    localparam logic [15:0] CNT_MAX = 16'hffff;

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : cat_pkg

// ### dv/tb.sv
// Self-checking bench for the counter array timebase.
// Assumes cat_pkg and cat_timebase are compiled first; the bench drives
// every port itself, with no partner model.
`timescale 1ns/1ps

module tb;
    import cat_pkg::*;

    logic CLK = 1'h0;
    logic RESET = 1'h1;
    logic [7:0] AWADDR = 8'h00;
    logic [7:0] ARADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic AWVALID = 1'h0;
    logic WVALID = 1'h0;
    logic BREADY = 1'h0;
    logic ARVALID = 1'h0;
    logic RREADY = 1'h0;
    logic CNT_PIN = 1'h1;
    logic OSC = 1'h0;
    logic TIMER0_OVF = 1'h0;
    logic CPU_IDLE = 1'h0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, OVF_REQ, IRQ;
    logic [1:0] BRESP, RRESP;
    logic [31:0] RDATA;
    logic [15:0] COUNT_VALUE;
    int n_mismatch = 0;
    int tests_run = 0;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] c0;

    cat_timebase cat_timebase_i (
        .CLK(CLK), .RESET(RESET),
        .S_AXI_AWADDR(AWADDR), .S_AXI_AWVALID(AWVALID),
        .S_AXI_AWREADY(AWREADY), .S_AXI_WDATA(WDATA),
        .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(WVALID), .S_AXI_WREADY(WREADY),
        .S_AXI_BRESP(BRESP), .S_AXI_BVALID(BVALID), .S_AXI_BREADY(BREADY),
        .S_AXI_ARADDR(ARADDR), .S_AXI_ARVALID(ARVALID),
        .S_AXI_ARREADY(ARREADY), .S_AXI_RDATA(RDATA), .S_AXI_RRESP(RRESP),
        .S_AXI_RVALID(RVALID), .S_AXI_RREADY(RREADY),
        .EXT_COUNT_IN(CNT_PIN), .EXT_OSC_DIV8(OSC), .TIMER0_OVF(TIMER0_OVF),
        .CPU_IDLE(CPU_IDLE), .COUNT_VALUE(COUNT_VALUE),
        .OVF_REQ(OVF_REQ), .IRQ(IRQ)
    );

    always #5 CLK = ~CLK;

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask : chk

    // Ready is judged at the falling edge, so the next rising edge takes it
    task wr(input logic [7:0] a, input logic [7:0] v, input logic p);
        @(posedge CLK);
        AWADDR <= a;
        WDATA <= {24'h000000, v};
        AWVALID <= 1'h1;
        WVALID <= 1'h1;
        BREADY <= 1'h1;
        TIMER0_OVF <= p;
        @(negedge CLK);
        while ((AWREADY & WREADY) !== 1'h1) begin
            @(negedge CLK);
        end
        @(posedge CLK);
        AWVALID <= 1'h0;
        WVALID <= 1'h0;
        TIMER0_OVF <= 1'h0;
        @(negedge CLK);
        while (BVALID !== 1'h1) begin
            @(negedge CLK);
        end
        r = BRESP;
        @(posedge CLK);
        BREADY <= 1'h0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge CLK);
        ARADDR <= a;
        ARVALID <= 1'h1;
        RREADY <= 1'h1;
        @(negedge CLK);
        while (ARREADY !== 1'h1) begin
            @(negedge CLK);
        end
        @(posedge CLK);
        ARVALID <= 1'h0;
        @(negedge CLK);
        while (RVALID !== 1'h1) begin
            @(negedge CLK);
        end
        d = RDATA;
        r = RRESP;
        @(posedge CLK);
        RREADY <= 1'h0;
    endtask : rd

    task tick(input int k);
        repeat (k) begin
            @(posedge CLK);
            TIMER0_OVF <= 1'h1;
            @(posedge CLK);
            TIMER0_OVF <= 1'h0;
        end
        @(negedge CLK);
    endtask : tick

    // Counter advance over a fixed window of clock cycles
    task span(input int cyc, input logic [15:0] exp);
        @(negedge CLK);
        c0 = COUNT_VALUE;
        repeat (cyc) @(negedge CLK);
        chk(16'(COUNT_VALUE - c0), exp);
    endtask : span

    task set_count(input logic [15:0] v);
        wr(ADDR_CNT_LO, v[7:0], 1'h0);
        wr(ADDR_CNT_HI, v[15:8], 1'h0);
    endtask : set_count

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_reset;
        rd(ADDR_MODE);
        chk(d, 32'h0);
        chk(r, RESP_OKAY);
        rd(ADDR_CTRL);
        chk(d, 32'h0);
        rd(ADDR_MSK);
        chk(d, 32'h0);
        rd(ADDR_STS);
        chk(d, 32'h0);
        rd(8'h18);
        chk(r, RESP_DECERR);
        wr(8'h1c, 8'hff, 1'h0);
        chk(r, RESP_DECERR);
        chk({IRQ, OVF_REQ}, 2'h0);
    endtask : t_reset

    task t_rates;
        logic [2:0] codes [6];
        int exps [6];
        codes = '{3'h0, 3'h1, 3'h4, 3'h2, 3'h6, 3'h7};
        exps = '{4, 12, 48, 0, 0, 0};
        for (int i = 0; i < 6; i++) begin
            wr(ADDR_MODE, {4'h0, codes[i], 1'h0}, 1'h0);
            span(48, exps[i][15:0]);
        end
    endtask : t_rates

    // Count pin held two cycles each level: the fastest legal rate
    task t_pins;
        wr(ADDR_MODE, 8'h06, 1'h0);
        @(negedge CLK);
        c0 = COUNT_VALUE;
        repeat (5) begin
            @(posedge CLK);
            CNT_PIN <= 1'h0;
            repeat (2) @(posedge CLK);
            CNT_PIN <= 1'h1;
            repeat (1) @(posedge CLK);
        end
        repeat (6) @(negedge CLK);
        chk(16'(COUNT_VALUE - c0), 16'h0005);
        wr(ADDR_MODE, 8'h0a, 1'h0);
        @(negedge CLK);
        c0 = COUNT_VALUE;
        repeat (5) begin
            repeat (4) @(posedge CLK);
            OSC <= 1'h1;
            repeat (4) @(posedge CLK);
            OSC <= 1'h0;
        end
        repeat (6) @(negedge CLK);
        chk(16'(COUNT_VALUE - c0), 16'h0005);
    endtask : t_pins

    task t_idle;
        wr(ADDR_MODE, 8'h88, 1'h0);
        CPU_IDLE <= 1'h1;
        repeat (6) @(posedge CLK);
        span(20, 16'h0000);
        wr(ADDR_MODE, 8'h08, 1'h0);
        span(20, 16'h0014);
        @(posedge CLK);
        CPU_IDLE <= 1'h0;
    endtask : t_idle

    task t_snap;
        wr(ADDR_MODE, 8'h04, 1'h0);
        set_count(16'h12fe);
        tick(1);
        rd(ADDR_CNT_LO);
        chk(d, 32'h000000ff);
        tick(1);
        chk(COUNT_VALUE, 16'h1300);
        rd(ADDR_CNT_HI);
        chk(d, 32'h00000012);
        rd(ADDR_CNT_LO);
        rd(ADDR_CNT_HI);
        chk(d, 32'h00000013);
        chk(COUNT_VALUE, 16'h1300);
    endtask : t_snap

    task t_ovf;
        wr(ADDR_MODE, 8'h05, 1'h0);
        wr(ADDR_MSK, 8'h01, 1'h0);
        chk(r, RESP_OKAY);
        set_count(16'hffff);
        chk(OVF_REQ, 1'h0);
        tick(1);
        chk(COUNT_VALUE, 16'h0000);
        chk({OVF_REQ, IRQ}, 2'h3);
        wr(ADDR_MODE, 8'h04, 1'h0);
        @(negedge CLK);
        chk(OVF_REQ, 1'h0);
        rd(ADDR_CTRL);
        chk(d, 32'h00000080);
        wr(ADDR_MSK, 8'h00, 1'h0);
        @(negedge CLK);
        chk(IRQ, 1'h0);
        wr(ADDR_MSK, 8'h01, 1'h0);
        @(negedge CLK);
        chk(IRQ, 1'h1);
        rd(ADDR_STS);
        chk(d, 32'h00000001);
        chk(IRQ, 1'h0);
        rd(ADDR_STS);
        chk(d, 32'h0);
        wr(ADDR_CTRL, 8'h00, 1'h0);
        rd(ADDR_CTRL);
        chk(d, 32'h0);
    endtask : t_ovf

    // Wrap lands on the very edge that takes the control write
    task t_rmw;
        set_count(16'hffff);
        wr(ADDR_CTRL, 8'h00, 1'h1);
        chk(COUNT_VALUE, 16'h0000);
        rd(ADDR_CTRL);
        chk(d, 32'h0);
        rd(ADDR_STS);
        chk(d, 32'h00000001);
        wr(ADDR_CTRL, 8'h80, 1'h0);
        rd(ADDR_CTRL);
        chk(d, 32'h00000080);
    endtask : t_rmw

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task stop_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20) @(posedge CLK);
        RESET <= 1'h0;
        t_reset();
        t_rates();
        t_pins();
        t_idle();
        t_snap();
        t_ovf();
        t_rmw();
        stop_test();
    end

    // Whole sequence needs well under 2000 cycles
    initial begin
        #100000;
        n_mismatch++;
        stop_test();
    end

endmodule : tb
